// ===== logic/bsb_consts.vh
// Notes on behaviour
// - pointer jump loads pc from z, flags untouched, two cycles.
// - pointer call sets pc to z, flags untouched, three cycles.
// - equal compare skip skips next instruction when operands match, no flags.
// - compares subtract without storing, update z n v c h, one cycle.
// - register bit skips test a register bit clear or set, no flags.
// - io bit skips test an io register bit clear or set, no flags.
// - flag branch tests a status bit, taken target is pc plus k plus one.
// - signed ge taken when n xor v is 0, lt when it is 1.
// - unsigned same-higher equals carry clear, lower equals carry set.
// - interrupt branches test the global interrupt enable flag.
// - half carry, transfer and overflow branches test their flag likewise.
// - io bit force sets or clears one io bit, two cycles, no flags.
// - rotates through carry update z c n v in one cycle.
// - bit store copies a register bit into the transfer flag.
// - bit load copies the transfer flag into a register bit, no flags.
// - each flag set or clear changes only its own flag in one cycle.
`ifndef BSB_CONSTS_VH
`define BSB_CONSTS_VH
`define BSB_FLAG_C      3'd0
`define BSB_FLAG_Z      3'd1
`define BSB_FLAG_N      3'd2
`define BSB_FLAG_V      3'd3
`define BSB_FLAG_S      3'd4
`define BSB_FLAG_H      3'd5
`define BSB_FLAG_T      3'd6
`define BSB_FLAG_I      3'd7
`define BSB_FLAGS_RESET 8'h00
`define BSB_PC_RESET    16'h0000
`define BSB_OP_NONE       5'd0
`define BSB_OP_PTR_JUMP   5'd1
`define BSB_OP_PTR_CALL   5'd2
`define BSB_OP_EQ_SKIP    5'd3
`define BSB_OP_CMP        5'd4
`define BSB_OP_CMP_CARRY  5'd5
`define BSB_OP_CMP_IMM    5'd6
`define BSB_OP_RBIT_CLR_SKIP 5'd7
`define BSB_OP_RBIT_SET_SKIP 5'd8
`define BSB_OP_IOBIT_CLR_SKIP 5'd9
`define BSB_OP_IOBIT_SET_SKIP 5'd10
`define BSB_OP_FLAG_SET_BR 5'd11
`define BSB_OP_FLAG_CLR_BR 5'd12
`define BSB_OP_SGE_BR     5'd13
`define BSB_OP_SLT_BR     5'd14
`define BSB_OP_IO_ONE     5'd15
`define BSB_OP_IO_ZERO    5'd16
`define BSB_OP_ROL        5'd17
`define BSB_OP_ROR        5'd18
`define BSB_OP_BIT_TO_T   5'd19
`define BSB_OP_T_TO_BIT   5'd20
`define BSB_OP_FLAG_SET   5'd21
`define BSB_OP_FLAG_CLR   5'd22
`define BSB_OP_RET        5'd23
`define BSB_OP_IRQ_RET    5'd24
`define BSB_CYC_PTR_JUMP  3'd2
`define BSB_CYC_PTR_CALL  3'd3
`define BSB_CYC_IO_FORCE  3'd2
`define BSB_CYC_RET       3'd4
`define BSB_CYC_BR_TAKEN  3'd2
`define BSB_CYC_SKIP_ONE  3'd2
`define BSB_CYC_SKIP_TWO  3'd3
`define BSB_CYC_SINGLE    3'd1
`endif

// ===== logic/bsb_flag_file.v
`timescale 1ns/1ps
`include "bsb_consts.vh"
// status flag holder: one write port for a full byte, one single-bit port
module bsb_flag_file (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       wr_all,
    input  wire [7:0] wr_data,
    input  wire       wr_bit,
    input  wire [2:0] bit_sel,
    input  wire       bit_val,
    output reg  [7:0] flags
);
    always @(posedge clk) begin
        if (!reset_n) begin
            flags <= `BSB_FLAGS_RESET;
        end else if (wr_all) begin
            flags <= wr_data;
        end else if (wr_bit) begin
            flags[bit_sel] <= bit_val;
        end
    end
endmodule // bsb_flag_file

// ===== logic/bsb_unit.v
`timescale 1ns/1ps
`include "bsb_consts.vh"
module bsb_unit (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        op_valid,
    input  wire [4:0]  op_code,
    input  wire [7:0]  reg_a,
    input  wire [7:0]  reg_b,
    input  wire [2:0]  bit_sel,
    input  wire [11:0] offset,
    input  wire [15:0] z_pointer,
    input  wire [15:0] stack_pc,
    input  wire [15:0] pc_now,
    input  wire        next_two_word,
    input  wire [7:0]  io_data,
    output reg         busy,
    output reg         done,
    output reg  [15:0] pc_out,
    output reg         pc_load,
    output reg         push_ret,
    output reg  [7:0]  result,
    output reg         result_we,
    output reg  [7:0]  io_wr_data,
    output reg         io_we,
    output reg  [7:0]  status_flags_reg
);
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    reg        state;
    reg [2:0]  cyc_left;
    reg [15:0] pend_pc;
    reg        pend_load;
    wire [7:0] flags;
    // one accept term keeps flag writes and refusal in step
    wire       take_op = op_valid & (state == ST_IDLE);

    reg        next_wr_all;
    reg [7:0]  next_flags;
    reg        next_wr_bit;
    reg        next_bit_val;
    reg [2:0]  next_cycles;
    reg [15:0] next_pc;
    reg        next_load;
    reg        next_push;
    reg [7:0]  next_result;
    reg        next_result_we;
    reg [7:0]  next_io;
    reg        next_io_we;
    reg [8:0]  diff;
    reg [7:0]  rot;
    reg        taken;

    // relative target; offset is sign extended to the pc width
    function [15:0] rel_target;
        input [15:0] pc;
        input [11:0] k;
        begin
            rel_target = pc + {{4{k[11]}}, k} + 16'h0001;
        end
    endfunction

    // skip distance depends on the length of the instruction skipped
    function [15:0] skip_target;
        input [15:0] pc;
        input        two;
        begin
            skip_target = two ? pc + 16'h0003 : pc + 16'h0002;
        end
    endfunction

    // one decode for every skip and branch condition
    function cond_met;
        input [4:0] op;
        input [7:0] a;
        input [7:0] b;
        input [7:0] io;
        input [7:0] f;
        input [2:0] sel;
        begin
            case (op)
            `BSB_OP_EQ_SKIP:        cond_met = (a == b);
            `BSB_OP_RBIT_CLR_SKIP:  cond_met = ~a[sel];
            `BSB_OP_RBIT_SET_SKIP:  cond_met = a[sel];
            `BSB_OP_IOBIT_CLR_SKIP: cond_met = ~io[sel];
            `BSB_OP_IOBIT_SET_SKIP: cond_met = io[sel];
            // named branches on c, h, t, v, i map onto these by bit index
            `BSB_OP_FLAG_SET_BR:    cond_met = f[sel];
            `BSB_OP_FLAG_CLR_BR:    cond_met = ~f[sel];
            `BSB_OP_SGE_BR:
                cond_met = ~(f[`BSB_FLAG_N] ^ f[`BSB_FLAG_V]);
            `BSB_OP_SLT_BR:
                cond_met = f[`BSB_FLAG_N] ^ f[`BSB_FLAG_V];
            default:                cond_met = 1'b0;
            endcase
        end
    endfunction

    // flags are written only at acceptance, so refused requests leave them
    bsb_flag_file u_flags (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_all  (next_wr_all & take_op),
        .wr_data (next_flags),
        .wr_bit  (next_wr_bit & take_op),
        .bit_sel (bit_sel),
        .bit_val (next_bit_val),
        .flags   (flags)
    );

    always @* begin
        next_wr_all    = 1'b0;
        next_flags     = flags;
        next_wr_bit    = 1'b0;
        next_bit_val   = 1'b0;
        next_cycles    = `BSB_CYC_SINGLE;
        next_pc        = pc_now + 16'h0001;
        next_load      = 1'b0;
        next_push      = 1'b0;
        next_result    = reg_a;
        next_result_we = 1'b0;
        next_io        = io_data;
        next_io_we     = 1'b0;
        diff           = 9'h000;
        rot            = 8'h00;
        taken          = 1'b0;

        case (op_code)
        `BSB_OP_PTR_JUMP: begin
            next_pc     = z_pointer;
            next_load   = 1'b1;
            next_cycles = `BSB_CYC_PTR_JUMP;
        end

        `BSB_OP_PTR_CALL: begin
            next_pc     = z_pointer;
            next_load   = 1'b1;
            next_push   = 1'b1;
            next_cycles = `BSB_CYC_PTR_CALL;
        end

        `BSB_OP_RET, `BSB_OP_IRQ_RET: begin
            next_pc     = stack_pc;
            next_load   = 1'b1;
            next_cycles = `BSB_CYC_RET;
            if (op_code == `BSB_OP_IRQ_RET) begin
                next_wr_all = 1'b1;
                next_flags[`BSB_FLAG_I] = 1'b1;
            end
        end

        `BSB_OP_EQ_SKIP, `BSB_OP_RBIT_CLR_SKIP, `BSB_OP_RBIT_SET_SKIP,
        `BSB_OP_IOBIT_CLR_SKIP, `BSB_OP_IOBIT_SET_SKIP: begin
            taken = cond_met(op_code, reg_a, reg_b, io_data, flags, bit_sel);
            if (taken) begin
                next_pc     = skip_target(pc_now, next_two_word);
                next_load   = 1'b1;
                next_cycles = next_two_word ? `BSB_CYC_SKIP_TWO
                                            : `BSB_CYC_SKIP_ONE;
            end
        end

        `BSB_OP_CMP, `BSB_OP_CMP_CARRY, `BSB_OP_CMP_IMM: begin
            // no result write; reg_b carries the immediate for the imm form
            diff = {1'b0, reg_a} - {1'b0, reg_b}
                 - {8'h00, (op_code == `BSB_OP_CMP_CARRY) &
                           flags[`BSB_FLAG_C]};
            next_wr_all = 1'b1;
            next_flags[`BSB_FLAG_C] = diff[8];
            // carry-compare keeps z clear unless it was already set
            next_flags[`BSB_FLAG_Z] = (diff[7:0] == 8'h00) &
                ((op_code != `BSB_OP_CMP_CARRY) | flags[`BSB_FLAG_Z]);
            next_flags[`BSB_FLAG_N] = diff[7];
            next_flags[`BSB_FLAG_V] = (reg_a[7] & ~reg_b[7] & ~diff[7]) |
                                      (~reg_a[7] & reg_b[7] & diff[7]);
            next_flags[`BSB_FLAG_H] = (~reg_a[3] & reg_b[3]) |
                                      (reg_b[3] & diff[3]) |
                                      (diff[3] & ~reg_a[3]);
        end

        `BSB_OP_FLAG_SET_BR, `BSB_OP_FLAG_CLR_BR, `BSB_OP_SGE_BR,
        `BSB_OP_SLT_BR: begin
            taken = cond_met(op_code, reg_a, reg_b, io_data, flags, bit_sel);
            if (taken) begin
                next_pc     = rel_target(pc_now, offset);
                next_load   = 1'b1;
                next_cycles = `BSB_CYC_BR_TAKEN;
            end
        end

        `BSB_OP_IO_ONE, `BSB_OP_IO_ZERO: begin
            next_io          = io_data;
            next_io[bit_sel] = (op_code == `BSB_OP_IO_ONE);
            next_io_we       = 1'b1;
            next_cycles      = `BSB_CYC_IO_FORCE;
        end

        `BSB_OP_ROL, `BSB_OP_ROR: begin
            if (op_code == `BSB_OP_ROL) begin
                rot = {reg_a[6:0], flags[`BSB_FLAG_C]};
                next_flags[`BSB_FLAG_C] = reg_a[7];
            end else begin
                rot = {flags[`BSB_FLAG_C], reg_a[7:1]};
                next_flags[`BSB_FLAG_C] = reg_a[0];
            end
            next_flags[`BSB_FLAG_Z] = (rot == 8'h00);
            next_flags[`BSB_FLAG_N] = rot[7];
            next_flags[`BSB_FLAG_V] = rot[7] ^ next_flags[`BSB_FLAG_C];
            next_wr_all    = 1'b1;
            next_result    = rot;
            next_result_we = 1'b1;
        end

        `BSB_OP_BIT_TO_T: begin
            next_wr_all = 1'b1;
            next_flags[`BSB_FLAG_T] = reg_a[bit_sel];
        end

        `BSB_OP_T_TO_BIT: begin
            next_result          = reg_a;
            next_result[bit_sel] = flags[`BSB_FLAG_T];
            next_result_we       = 1'b1;
        end

        `BSB_OP_FLAG_SET, `BSB_OP_FLAG_CLR: begin
            next_wr_bit  = 1'b1;
            next_bit_val = (op_code == `BSB_OP_FLAG_SET);
        end

        default: begin
            next_cycles = `BSB_CYC_SINGLE;
        end
        endcase
    end

    // side effects land at acceptance; pc load waits out the cycle count
    always @(posedge clk) begin
        if (!reset_n) begin
            state      <= ST_IDLE;
            cyc_left   <= 3'd0;
            pend_pc    <= `BSB_PC_RESET;
            pend_load  <= 1'b0;
            busy       <= 1'b0;
            done       <= 1'b0;
            pc_out     <= `BSB_PC_RESET;
            pc_load    <= 1'b0;
            push_ret   <= 1'b0;
            result     <= 8'h00;
            result_we  <= 1'b0;
            io_wr_data <= 8'h00;
            io_we      <= 1'b0;
            status_flags_reg <= `BSB_FLAGS_RESET;
        end else begin
            status_flags_reg <= flags;
            push_ret  <= 1'b0;
            result_we <= 1'b0;
            io_we     <= 1'b0;
            done      <= 1'b0;
            pc_load   <= 1'b0;
            case (state)
            ST_IDLE: begin
                if (op_valid) begin
                    result     <= next_result;
                    result_we  <= next_result_we;
                    io_wr_data <= next_io;
                    io_we      <= next_io_we;
                    push_ret   <= next_push;
                    if (next_cycles == `BSB_CYC_SINGLE) begin
                        done    <= 1'b1;
                        pc_out  <= next_pc;
                        pc_load <= next_load;
                    end else begin
                        state     <= ST_WAIT;
                        busy      <= 1'b1;
                        cyc_left  <= next_cycles - 3'd1;
                        pend_pc   <= next_pc;
                        pend_load <= next_load;
                    end
                end
            end

            // op_valid is not looked at here, so requests while busy drop
            ST_WAIT: begin
                cyc_left <= cyc_left - 3'd1;
                if (cyc_left == 3'd1) begin
                    state   <= ST_IDLE;
                    busy    <= 1'b0;
                    done    <= 1'b1;
                    pc_out  <= pend_pc;
                    pc_load <= pend_load;
                end
            end

            default: begin
                state <= ST_IDLE;
                busy  <= 1'b0;
            end
            endcase
        end
    end
endmodule // bsb_unit

// ===== testbench/bsb_unit_props.sv
`timescale 1ns/1ps
`include "bsb_consts.vh"
module bsb_unit_props (
    input wire        clk,
    input wire        reset_n,
    input wire        op_valid,
    input wire [4:0]  op_code,
    input wire [7:0]  reg_a,
    input wire [7:0]  reg_b,
    input wire [2:0]  bit_sel,
    input wire [15:0] z_pointer,
    input wire [15:0] stack_pc,
    input wire [15:0] pc_now,
    input wire        next_two_word,
    input wire [7:0]  io_data,
    input wire        busy,
    input wire        done,
    input wire [15:0] pc_out,
    input wire        pc_load,
    input wire        push_ret,
    input wire [7:0]  io_wr_data,
    input wire        io_we,
    input wire [7:0]  status_flags_reg
);
    wire acc = op_valid && !busy;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_jump_target: assert property (
        acc && op_code == `BSB_OP_PTR_JUMP |-> ##1 !done
        ##1 done && pc_load && pc_out == $past(z_pointer, 2))
        else $error("pointer jump target or timing wrong");
    a_jump_flags: assert property (
        acc && op_code == `BSB_OP_PTR_JUMP |-> ##2 $stable(status_flags_reg))
        else $error("pointer jump changed flags");
    a_call_push: assert property (
        acc && op_code == `BSB_OP_PTR_CALL |-> ##1 push_ret && busy ##1 busy
        ##1 done && pc_load && pc_out == $past(z_pointer, 3))
        else $error("pointer call sequence wrong");
    a_ret_four: assert property (
        acc && (op_code == `BSB_OP_RET || op_code == `BSB_OP_IRQ_RET)
        |-> ##1 busy [*3] ##1 done && pc_out == $past(stack_pc, 4))
        else $error("return timing or target wrong");
    a_irq_ret_flag: assert property (
        acc && op_code == `BSB_OP_IRQ_RET |-> ##2 status_flags_reg[7])
        else $error("irq return left interrupt flag clear");
    a_skip_equal: assert property (
        acc && op_code == `BSB_OP_EQ_SKIP && reg_a == reg_b && !next_two_word
        |-> ##2 done && pc_load && pc_out == $past(pc_now, 2) + 16'h0002)
        else $error("equal skip target wrong");
    a_skip_none: assert property (
        acc && op_code == `BSB_OP_EQ_SKIP && reg_a != reg_b
        |-> ##1 done && !pc_load && pc_out == $past(pc_now) + 16'h0001)
        else $error("unequal compare skip did not fall through");
    a_io_zero: assert property (
        acc && op_code == `BSB_OP_IO_ZERO |-> ##1 io_we
        && io_wr_data == ($past(io_data) & ~(8'h01 << $past(bit_sel)))
        ##1 done)
        else $error("io bit clear wrong");
    a_rol_carry: assert property (
        acc && op_code == `BSB_OP_ROL
        |-> ##2 status_flags_reg[0] == $past(reg_a[7], 2))
        else $error("rotate left carry wrong");
    a_flag_set: assert property (
        acc && op_code == `BSB_OP_FLAG_SET
        |-> ##2 status_flags_reg[$past(bit_sel, 2)])
        else $error("flag set did not take");

    cover property (acc && op_code == `BSB_OP_EQ_SKIP && next_two_word
        ##3 done);
    cover property (done && pc_load);
    cover property (acc ##1 acc);
endmodule // bsb_unit_props

bind bsb_unit bsb_unit_props i_props (
    .clk              (clk),
    .reset_n          (reset_n),
    .op_valid         (op_valid),
    .op_code          (op_code),
    .reg_a            (reg_a),
    .reg_b            (reg_b),
    .bit_sel          (bit_sel),
    .z_pointer        (z_pointer),
    .stack_pc         (stack_pc),
    .pc_now           (pc_now),
    .next_two_word    (next_two_word),
    .io_data          (io_data),
    .busy             (busy),
    .done             (done),
    .pc_out           (pc_out),
    .pc_load          (pc_load),
    .push_ret         (push_ret),
    .io_wr_data       (io_wr_data),
    .io_we            (io_we),
    .status_flags_reg (status_flags_reg)
);

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`include "bsb_consts.vh"
module testbench;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        op_valid = 1'b0;
    logic        next_two_word = 1'b0;
    logic [4:0]  op_code = 5'h00;
    logic [7:0]  reg_a = 8'h00, reg_b = 8'h00, io_data = 8'h00;
    logic [2:0]  bit_sel = 3'h0;
    logic [11:0] offset = 12'h000;
    logic [15:0] z_pointer = 16'h0000, stack_pc = 16'h0000;
    logic [15:0] pc_now = 16'h0000;
    wire         busy, done, pc_load, push_ret, result_we, io_we;
    wire  [15:0] pc_out;
    wire  [7:0]  result, io_wr_data, status_flags_reg;
    logic [31:0] lfsr = 32'h19fe2825;
    logic [16:0] q_pc[$];
    logic [7:0]  q_res[$], q_io[$];
    logic [7:0]  f = 8'h00;
    int          n_fail = 0, cmp_count = 0;

    bsb_unit i_dut (
        .clk              (clk),
        .reset_n          (reset_n),
        .op_valid         (op_valid),
        .op_code          (op_code),
        .reg_a            (reg_a),
        .reg_b            (reg_b),
        .bit_sel          (bit_sel),
        .offset           (offset),
        .z_pointer        (z_pointer),
        .stack_pc         (stack_pc),
        .pc_now           (pc_now),
        .next_two_word    (next_two_word),
        .io_data          (io_data),
        .busy             (busy),
        .done             (done),
        .pc_out           (pc_out),
        .pc_load          (pc_load),
        .push_ret         (push_ret),
        .result           (result),
        .result_we        (result_we),
        .io_wr_data       (io_wr_data),
        .io_we            (io_we),
        .status_flags_reg (status_flags_reg)
    );
    always #50 clk = ~clk;

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic cmp_pc(input logic [16:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_byte(input logic [7:0] got, exp);
        cmp_pc({9'h000, got}, {9'h000, exp});
    endtask

    // outputs settle 1 ns after the edge; notes come off the queues in order
    always @(posedge clk) begin
        #1;
        if (reset_n && done)
            cmp_pc({pc_load, pc_out}, q_pc.pop_front());
        if (reset_n && result_we)
            cmp_byte(result, q_res.pop_front());
        if (reset_n && io_we)
            cmp_byte(io_wr_data, q_io.pop_front());
    end

    task automatic run(input logic [4:0] op);
        logic [7:0]  a, b, r;
        logic [2:0]  s;
        logic [11:0] k;
        logic [15:0] pc, z, st, tgt;
        logic        two, ld, sk, bt, c;
        int          cyc, n;
        lfsr = nxt(lfsr);
        {a, b, s, k, two} = lfsr;
        if (op == `BSB_OP_EQ_SKIP && k[0]) b = a;
        lfsr = nxt(lfsr);
        {pc, z} = lfsr;
        st = ~lfsr[23:8];
        tgt = pc + 16'h0001;
        {ld, sk, bt, r} = {3'b000, a};
        cyc = 1;
        case (op)
            `BSB_OP_PTR_JUMP: begin ld = 1; tgt = z; cyc = 2; end
            `BSB_OP_PTR_CALL: begin ld = 1; tgt = z; cyc = 3; end
            `BSB_OP_RET: begin ld = 1; tgt = st; cyc = 4; end
            `BSB_OP_IRQ_RET: begin ld = 1; tgt = st; cyc = 4; f[7] = 1; end
            `BSB_OP_EQ_SKIP: sk = a == b;
            `BSB_OP_RBIT_CLR_SKIP: sk = !a[s];
            `BSB_OP_RBIT_SET_SKIP: sk = a[s];
            `BSB_OP_IOBIT_CLR_SKIP: sk = !b[s];
            `BSB_OP_IOBIT_SET_SKIP: sk = b[s];
            `BSB_OP_FLAG_SET_BR: bt = f[s];
            `BSB_OP_FLAG_CLR_BR: bt = !f[s];
            `BSB_OP_SGE_BR: bt = !(f[2] ^ f[3]);
            `BSB_OP_SLT_BR: bt = f[2] ^ f[3];
            `BSB_OP_IO_ONE: begin
                q_io.push_back(b | (8'h01 << s));
                cyc = 2;
            end
            `BSB_OP_IO_ZERO: begin
                q_io.push_back(b & ~(8'h01 << s));
                cyc = 2;
            end
            `BSB_OP_ROL: begin r = {a[6:0], f[0]}; f[0] = a[7]; end
            `BSB_OP_ROR: begin r = {f[0], a[7:1]}; f[0] = a[0]; end
            `BSB_OP_BIT_TO_T: f[6] = a[s];
            `BSB_OP_T_TO_BIT: begin
                r[s] = f[6];
                q_res.push_back(r);
            end
            `BSB_OP_FLAG_SET: f[s] = 1'b1;
            `BSB_OP_FLAG_CLR: f[s] = 1'b0;
            default: begin
                c = (op == `BSB_OP_CMP_CARRY) & f[0];
                r = a - b - {7'h00, c};
                f[5] = !a[3] & b[3] | b[3] & r[3] | r[3] & !a[3];
                f[3] = a[7] & !b[7] & !r[7] | !a[7] & b[7] & r[7];
                f[0] = !a[7] & b[7] | b[7] & r[7] | r[7] & !a[7];
                f[2] = r[7];
                f[1] = (r == 8'h00) & (op != `BSB_OP_CMP_CARRY | f[1]);
            end
        endcase
        if (op == `BSB_OP_ROL || op == `BSB_OP_ROR) begin
            q_res.push_back(r);
            f[1] = r == 8'h00;
            f[2] = r[7];
            f[3] = r[7] ^ f[0];
        end
        if (sk) begin ld = 1; cyc = two ? 3 : 2; tgt = pc + 16'(cyc); end
        if (bt) begin ld = 1; cyc = 2; tgt = pc + {{4{k[11]}}, k} + 16'h1; end
        @(negedge clk);
        {op_code, reg_a, reg_b, bit_sel, offset} = {op, a, b, s, k};
        {next_two_word, io_data, z_pointer} = {two, b, z};
        {stack_pc, pc_now} = {st, pc};
        op_valid = 1'b1;
        q_pc.push_back({ld, tgt});
        @(negedge clk);
        n = 1;
        while (done !== 1'b1 && n < 9) begin
            // a request raised while busy must be ignored
            op_code = `BSB_OP_FLAG_SET;
            op_valid = busy === 1'b1;
            @(negedge clk);
            n++;
        end
        op_valid = 1'b0;
        cmp_byte(8'(n), 8'(cyc));
        @(negedge clk);
        cmp_byte(status_flags_reg, f);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #500000;
        n_fail++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        // every code from 1 to 24 once in order, then a random mix
        for (int i = 0; i < 424; i++) begin
            lfsr = nxt(lfsr);
            run(i < 24 ? 5'(i + 1) : 5'd1 + 5'(lfsr[7:0] % 8'd24));
        end
        $display("operation mix finished");
        repeat (3) @(negedge clk);
        results();
    end
endmodule // testbench
